/* File: verilog/pcirq_pkg.sv */
// constants, register map and field layout of the pin change interrupt block
// assumes an apb slave with 32-bit data and word aligned registers
//
// Notes on behaviour
// - each pin has a rising edge detector that works only while its rise enable bit is one.
// - each pin has a falling edge detector that works only while its fall enable bit is one.
// - with both enable bits set a pin flags rising and falling edges alike.
// - an enabled edge sets that pin's sticky bit in the change flag register.
// - detection and flag setting go on while the master enable is clear.
// - an interrupt request is raised only while the master enable is set.
// - the summary flag reads one whenever any per-pin flag is set.
// - writing zero to a flag bit clears it and writing one leaves it as it was.
// - an edge arriving during a flag register write leaves that flag set whatever is written.
// - an enabled edge wakes the device from sleep while the master enable and that pin's mask bit are set.
// - a flag for an edge seen in sleep is set before the wake request is given.
// - the rise enable register is eight read/write bits, one per pin, reset to zero.
// - the fall enable register is eight read/write bits, one per pin, reset to zero.
// - the change flag register is eight bits, read/write and set by hardware, reset to zero.
package pcirq_pkg;
   localparam int          PCIRQ_PINS        = 8;
   localparam logic [11:0] PCIRQ_OFF_RISE    = 12'h000;
   localparam logic [11:0] PCIRQ_OFF_FALL    = 12'h004;
   localparam logic [11:0] PCIRQ_OFF_FLAGS   = 12'h008;
   localparam logic [11:0] PCIRQ_OFF_CTRL    = 12'h00c;
   localparam logic [11:0] PCIRQ_OFF_MASK    = 12'h010;
   localparam int          PCIRQ_CTRL_MASTER = 0;
   localparam int          PCIRQ_CTRL_SUM    = 1;
   localparam logic [7:0]  PCIRQ_RESET_BYTE  = 8'h00;
   localparam logic [31:0] PCIRQ_UNMAPPED    = 32'h0000_0000;
endpackage

/* File: verilog/pcirq_sync.sv */
// two flip-flop synchroniser for one pin plus edge detection
// assumes pin is asynchronous to ref_clk
`timescale 1ns/1ns
`default_nettype none
module pcirq_sync
(
   input  wire logic ref_clk,
   input  wire logic arst_n,
   input  wire logic pin,
   output logic      rise_pulse,
   output logic      fall_pulse
);
   logic meta;
   logic stable;
   logic last;

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta   <= 1'b0;
         stable <= 1'b0;
         last   <= 1'b0;
      end
      else
      begin
         meta   <= pin;
         stable <= meta;
         last   <= stable;
      end
   end

   // compare the two settled samples only, never the first stage
   assign rise_pulse = stable & ~last;
   assign fall_pulse = ~stable & last;

   chk_rise_one_cycle : assert property (@(posedge ref_clk) disable iff (!arst_n)
      rise_pulse |=> !rise_pulse) else $error("rise pulse longer than one cycle");
endmodule
`default_nettype wire

/* File: verilog/pcirq_flag.sv */
// one sticky change flag with set-over-clear priority
// assumes set and write come from logic on ref_clk
`timescale 1ns/1ns
`default_nettype none
module pcirq_flag
(
   input  wire logic ref_clk,
   input  wire logic arst_n,
   input  wire logic set_evt,
   input  wire logic wr_en,
   input  wire logic wr_bit,
   output logic      flag
);
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         flag <= 1'b0;
      else if (set_evt)
         flag <= 1'b1;
      else if (wr_en && !wr_bit)
         flag <= 1'b0;
   end

   chk_set_wins : assert property (@(posedge ref_clk) disable iff (!arst_n)
      set_evt |=> flag) else $error("flag not set after event");
   chk_one_keeps : assert property (@(posedge ref_clk) disable iff (!arst_n)
      (wr_en && wr_bit && flag) |=> flag) else $error("write of one cleared flag");
endmodule
`default_nettype wire

/* File: verilog/pcirq_top.sv */
// pin change interrupt block: eight pins, edge enables, sticky flags, apb registers
// assumes pins are asynchronous; apb master on ref_clk
`timescale 1ns/1ns
`default_nettype none
module pcirq_top
   import pcirq_pkg::*;
#(
   parameter int PINS = PCIRQ_PINS
)
(
   input  wire logic            ref_clk,
   input  wire logic            arst_n,
   input  wire logic [PINS-1:0] port_pins,
   input  wire logic            sleeping,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [11:0]     paddr,
   input  wire logic [31:0]     pwdata,
   input  wire logic [3:0]      pstrb,
   output logic [31:0]          prdata,
   output logic                 pready,
   output logic                 pslverr,
   output logic                 irq,
   output logic                 wake_req
);
   ////////////////////////////////////////////////////////////////////////////
   logic [PINS-1:0] rising_edge_enable;
   logic [PINS-1:0] falling_edge_enable;
   logic [PINS-1:0] change_flags;
   logic [PINS-1:0] flag_mask;
   logic            change_irq_master_enable;
   logic [PINS-1:0] rise_pulse;
   logic [PINS-1:0] fall_pulse;
   logic [PINS-1:0] hit;
   logic            change_irq_summary_flag;
   logic            wr_access;
   logic            lane0;
   logic            next_pslverr;
   logic [31:0]     next_prdata;

   // access phase completes in one cycle; strobe lane 0 carries all bits
   assign wr_access = psel && penable && pwrite;
   assign lane0     = pstrb[0];
   assign pready    = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   genvar g;
   generate
      for (g = 0; g < PINS; g++)
      begin : g_pin
         pcirq_sync u_sync
         (
            .ref_clk    (ref_clk),
            .arst_n     (arst_n),
            .pin        (port_pins[g]),
            .rise_pulse (rise_pulse[g]),
            .fall_pulse (fall_pulse[g])
         );
         // both detectors may be on together
         assign hit[g] = (rise_pulse[g] & rising_edge_enable[g])
                       | (fall_pulse[g] & falling_edge_enable[g]);
         // detection ignores the master enable
         pcirq_flag u_flag
         (
            .ref_clk (ref_clk),
            .arst_n  (arst_n),
            .set_evt (hit[g]),
            .wr_en   (wr_access && lane0 && paddr == PCIRQ_OFF_FLAGS),
            .wr_bit  (pwdata[g]),
            .flag    (change_flags[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rising_edge_enable       <= PCIRQ_RESET_BYTE[PINS-1:0];
         falling_edge_enable      <= PCIRQ_RESET_BYTE[PINS-1:0];
         flag_mask                <= PCIRQ_RESET_BYTE[PINS-1:0];
         change_irq_master_enable <= 1'b0;
      end
      else if (wr_access && lane0)
      begin
         unique case (paddr)
            PCIRQ_OFF_RISE:  rising_edge_enable  <= pwdata[PINS-1:0];
            PCIRQ_OFF_FALL:  falling_edge_enable <= pwdata[PINS-1:0];
            PCIRQ_OFF_MASK:  flag_mask           <= pwdata[PINS-1:0];
            PCIRQ_OFF_CTRL:  change_irq_master_enable <= pwdata[PCIRQ_CTRL_MASTER];
            default:         ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // summary flag is combinational so it tracks every flag change
   assign change_irq_summary_flag = |change_flags;

   always_comb
   begin
      next_prdata  = PCIRQ_UNMAPPED;
      next_pslverr = 1'b0;
      unique case (paddr)
         PCIRQ_OFF_RISE:  next_prdata[PINS-1:0] = rising_edge_enable;
         PCIRQ_OFF_FALL:  next_prdata[PINS-1:0] = falling_edge_enable;
         PCIRQ_OFF_FLAGS: next_prdata[PINS-1:0] = change_flags;
         PCIRQ_OFF_MASK:  next_prdata[PINS-1:0] = flag_mask;
         PCIRQ_OFF_CTRL:
         begin
            next_prdata[PCIRQ_CTRL_MASTER] = change_irq_master_enable;
            next_prdata[PCIRQ_CTRL_SUM]    = change_irq_summary_flag;
         end
         default:         next_pslverr = 1'b1;
      endcase
   end

   // read data registered in setup phase, valid during the access phase
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= next_prdata;
   end

   assign pslverr = psel && penable && next_pslverr;

   ////////////////////////////////////////////////////////////////////////////
   // the mask gates per-pin flags; the master enable gates both irq and wake_req
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         irq      <= 1'b0;
         wake_req <= 1'b0;
      end
      else
      begin
         irq      <= change_irq_master_enable && |(change_flags & flag_mask);
         // wake follows the flag by one cycle, so software sees it set
         wake_req <= sleeping && change_irq_master_enable
                     && |(change_flags & flag_mask);
      end
   end

   chk_irq_needs_master : assert property (@(posedge ref_clk) disable iff (!arst_n)
      irq |-> $past(change_irq_master_enable)) else $error("irq without master enable");
   chk_summary_any : assert property (@(posedge ref_clk) disable iff (!arst_n)
      change_irq_summary_flag == (change_flags != '0)) else $error("summary mismatch");
   chk_wake_flag_first : assert property (@(posedge ref_clk) disable iff (!arst_n)
      $rose(wake_req) |-> $past(change_flags != '0)) else $error("wake before flag");
   chk_wake_master : assert property (@(posedge ref_clk) disable iff (!arst_n)
      (sleeping && change_irq_master_enable && |(change_flags & flag_mask)) |=> wake_req)
      else $error("no wake on enabled event");
   chk_rise_flags : assert property (@(posedge ref_clk) disable iff (!arst_n)
      (rise_pulse[0] && rising_edge_enable[0]) |=> change_flags[0])
      else $error("rising edge not flagged");
   chk_fall_flags : assert property (@(posedge ref_clk) disable iff (!arst_n)
      (fall_pulse[0] && falling_edge_enable[0]) |=> change_flags[0])
      else $error("falling edge not flagged");
   chk_no_master_flag : assert property (@(posedge ref_clk) disable iff (!arst_n)
      (!change_irq_master_enable && hit[1]) |=> change_flags[1])
      else $error("flag lost with master off");
   chk_rise_reg_write : assert property (@(posedge ref_clk) disable iff (!arst_n)
      (wr_access && lane0 && paddr == PCIRQ_OFF_RISE) |=> rising_edge_enable == $past(pwdata[7:0]))
      else $error("rise enable write lost");
   chk_fall_reg_write : assert property (@(posedge ref_clk) disable iff (!arst_n)
      (wr_access && lane0 && paddr == PCIRQ_OFF_FALL) |=> falling_edge_enable == $past(pwdata[7:0]))
      else $error("fall enable write lost");
endmodule
`default_nettype wire

/* File: verification/test_pcirq_top.sv */
// self-checking bench for the pin change interrupt block, apb register tasks
// assumes the block answers apb with zero wait states and pins settle in six cycles
`timescale 1ns/1ns
`default_nettype none
module test_pcirq_top
   import pcirq_pkg::*;
;
   logic        ref_clk   = 1'b0;
   logic        arst_n    = 1'b0;
   logic [7:0]  port_pins = 8'h00;
   logic        sleeping  = 1'b0;
   logic        psel      = 1'b0;
   logic        penable   = 1'b0;
   logic        pwrite    = 1'b0;
   logic [11:0] paddr     = 12'h000;
   logic [31:0] pwdata    = 32'h0000_0000;
   logic [3:0]  pstrb     = 4'hf;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        wake_req;
   logic [31:0] rdata;
   logic        slv;
   int          miscompares = 0;
   int          checks_done = 0;
   localparam logic [31:0] SUM = 32'h1 << PCIRQ_CTRL_SUM;
   localparam logic [31:0] MST = 32'h1 << PCIRQ_CTRL_MASTER;

   always #20 ref_clk = ~ref_clk;

   pcirq_top #(.PINS(8)) uut
   (
      .ref_clk   (ref_clk),
      .arst_n    (arst_n),
      .port_pins (port_pins),
      .sleeping  (sleeping),
      .psel      (psel),
      .penable   (penable),
      .pwrite    (pwrite),
      .paddr     (paddr),
      .pwdata    (pwdata),
      .pstrb     (pstrb),
      .prdata    (prdata),
      .pready    (pready),
      .pslverr   (pslverr),
      .irq       (irq),
      .wake_req  (wake_req)
   );

////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
      checks_done++;
      if (seen !== expv)
      begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask

   // no wait count assumed: only the bound guards against a dead slave
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         miscompares++;
      rdata = prdata;
      slv   = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] expv);
      apb(1'b0, a, 32'h0);
      chk(rdata, expv);
   endtask

   // pins step at an edge; six cycles cover sync, flag and irq latency
   task automatic pins(input logic [7:0] v);
      @(posedge ref_clk);
      port_pins <= v;
      repeat (6) @(posedge ref_clk);
   endtask

   task automatic wrap_up();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #200000;
      miscompares++;
      wrap_up();
   end

   initial
   begin
      repeat (12) @(posedge ref_clk);
      arst_n <= 1'b1;
      rd(PCIRQ_OFF_RISE, 32'h0);
      rd(PCIRQ_OFF_FALL, 32'h0);
      rd(PCIRQ_OFF_FLAGS, 32'h0);
      rd(PCIRQ_OFF_CTRL, 32'h0);
      rd(12'h020, PCIRQ_UNMAPPED);
      chk({31'h0, slv}, 32'h1);
      apb(1'b1, PCIRQ_OFF_RISE, 32'hffff_ffa5);
      rd(PCIRQ_OFF_RISE, 32'ha5);
      pstrb <= 4'he;
      apb(1'b1, PCIRQ_OFF_RISE, 32'h0);
      pstrb <= 4'hf;
      rd(PCIRQ_OFF_RISE, 32'ha5);
      apb(1'b1, PCIRQ_OFF_FALL, 32'h3c);
      rd(PCIRQ_OFF_FALL, 32'h3c);
      // pin 0 rise only, pin 1 fall only, pin 2 both; master stays off
      apb(1'b1, PCIRQ_OFF_RISE, 32'h05);
      apb(1'b1, PCIRQ_OFF_FALL, 32'h06);
      apb(1'b1, PCIRQ_OFF_MASK, 32'hff);
      pins(8'hff);
      rd(PCIRQ_OFF_FLAGS, 32'h05);
      chk({31'h0, irq}, 32'h0);
      rd(PCIRQ_OFF_CTRL, SUM);
      apb(1'b1, PCIRQ_OFF_FLAGS, 32'h0);
      rd(PCIRQ_OFF_FLAGS, 32'h0);
      pins(8'h00);
      rd(PCIRQ_OFF_FLAGS, 32'h06);
      apb(1'b1, PCIRQ_OFF_FLAGS, 32'hfb);
      rd(PCIRQ_OFF_FLAGS, 32'h02);
      apb(1'b1, PCIRQ_OFF_FLAGS, 32'hff);
      rd(PCIRQ_OFF_FLAGS, 32'h02);
      apb(1'b1, PCIRQ_OFF_FLAGS, 32'h0);
      rd(PCIRQ_OFF_CTRL, 32'h0);
      apb(1'b1, PCIRQ_OFF_CTRL, MST);
      sleeping <= 1'b1;
      pins(8'h01);
      chk({31'h0, irq}, 32'h1);
      chk({31'h0, wake_req}, 32'h1);
      rd(PCIRQ_OFF_FLAGS, 32'h01);
      sleeping <= 1'b0;
      // pin 2 rises while the clearing write is in flight
      @(posedge ref_clk);
      port_pins <= 8'h05;
      apb(1'b1, PCIRQ_OFF_FLAGS, 32'h0);
      rd(PCIRQ_OFF_FLAGS, 32'h04);
      chk({31'h0, wake_req}, 32'h0);
      apb(1'b1, PCIRQ_OFF_MASK, 32'hfb);
      rd(PCIRQ_OFF_CTRL, MST | SUM);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, PCIRQ_OFF_MASK, 32'hff);
      rd(PCIRQ_OFF_MASK, 32'hff);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, PCIRQ_OFF_FLAGS, 32'h0);
      rd(PCIRQ_OFF_FLAGS, 32'h0);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, PCIRQ_OFF_CTRL, 32'h0);
      pins(8'h00);
      rd(PCIRQ_OFF_FLAGS, 32'h04);
      chk({31'h0, irq}, 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
